// File: direction_load_and_xor_exec_test.sv
// self-checking testbench for the direction-load and xor executor
`timescale 1ns/1ps
module direction_load_and_xor_exec_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic insn_valid = 1'b0;
  logic [11:0] insn = 12'h000;
  logic [4:0] file_raddr;
  logic [7:0] file_rdata;
  logic file_we;
  logic [4:0] file_waddr;
  logic [7:0] file_wdata;
  logic [7:0] wreg;
  logic zero_flag;
  logic [7:0] dir5;
  logic [7:0] dir6;
  logic [7:0] dir7;
  logic [7:0] fmem [32];
  logic [7:0] writes = 8'h00;
  int fail_count = 0;
  int checked = 0;
  ////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk = ~clk;
  end
  dlx_exec dut (.clk(clk), .rst(rst), .insn_valid(insn_valid), .insn(insn), .file_raddr(file_raddr),
    .file_rdata(file_rdata), .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
    .wreg(wreg), .zero_flag(zero_flag), .first_port_direction(dir5),
    .second_port_direction(dir6), .third_port_direction(dir7));
  // file array: combinational read, write on the pulse
  assign file_rdata = fmem[file_raddr];
  always @(posedge clk) begin
    if (file_we) begin
      fmem[file_waddr] <= file_wdata;
      writes <= writes + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    if (fail_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task step(input logic [11:0] i);
    @(posedge clk);
    insn_valid <= 1'b1;
    insn <= i;
  endtask
  // extra edge lets the late file write land before sampling
  task idle;
    @(posedge clk);
    insn_valid <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_lit;
    step(12'hFB5);
    step(12'hFAF);
    idle;
    chk(wreg, 8'h1A);
    chk({7'h00, zero_flag}, 8'h00);
    step(12'hF1A);
    idle;
    chk(wreg, 8'h00);
    chk({7'h00, zero_flag}, 8'h01);
    chk(writes, 8'h00);
  endtask
  // the last literal xor sets the zero flag so that a flag write by the loads after it shows up
  task t_dir;
    step(12'hFA5);
    step(12'h005);
    step(12'hFFF);
    step(12'h006);
    step(12'hF5A);
    step(12'h007);
    step(12'h004);
    idle;
    chk(dir5, 8'hA5);
    chk(dir6, 8'h5A);
    chk(dir7, 8'h00);
    chk({7'h00, zero_flag}, 8'h01);
  endtask
  task t_reg;
    step(12'hFB5);
    step(12'h1A3);
    idle;
    chk(fmem[3], 8'h1A);
    chk(wreg, 8'hB5);
    chk({7'h00, zero_flag}, 8'h00);
    step(12'h184);
    idle;
    chk(wreg, 8'h00);
    chk(fmem[4], 8'hB5);
    chk({7'h00, zero_flag}, 8'h01);
    chk(writes, 8'h01);
  endtask
  // back-to-back xors on one address: each must see the one before
  task t_fwd;
    step(12'hF3C);
    step(12'h1A3);
    step(12'h1A3);
    step(12'h183);
    idle;
    chk(fmem[3], 8'h1A);
    chk(wreg, 8'h26);
    chk({7'h00, zero_flag}, 8'h00);
    chk(writes, 8'h03);
  endtask
  // mid-run reset, then the core must run again
  task t_rst;
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    #1;
    chk(dir5, 8'hFF);
    chk(dir7, 8'hFF);
    chk(wreg, 8'h00);
    chk({7'h00, zero_flag}, 8'h00);
    chk({7'h00, file_we}, 8'h00);
    @(posedge clk);
    rst <= 1'b0;
    step(12'hF3C);
    idle;
    chk(wreg, 8'h3C);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 32; i++)
      fmem[i] = 8'h00;
    fmem[3] = 8'hAF;
    fmem[4] = 8'hB5;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_lit;
    t_dir;
    t_reg;
    t_fwd;
    t_rst;
    wrap_up;
  end
  initial begin
    #20000;
    fail_count++;
    wrap_up;
  end
endmodule

// File: dlx_decode.sv
// instruction decoder for the three supported instructions
`timescale 1ns/1ps
module dlx_decode (
  // instruction
  input wire logic [11:0] insn,
  // decoded
  output dlx_pkg::dlx_op_e op,
  output logic [7:0] literal,
  output logic [4:0] faddr,
  output logic dest_file,
  output logic [1:0] port_idx
);
  logic [2:0] psel;
  assign psel = insn[2:0];
  assign literal = insn[7:0];
  assign faddr = insn[4:0];
  assign dest_file = insn[dlx_pkg::DEST_BIT] != dlx_pkg::DEST_WREG;
  assign port_idx = 2'(psel - dlx_pkg::PORT_SEL_FIRST);
  always_comb begin
    op = dlx_pkg::OP_NONE;
    // other port selects are not direction loads
    if (insn[11:dlx_pkg::DIR_LOAD_OPC_LSB] == dlx_pkg::DIR_LOAD_OPC &&
        psel >= dlx_pkg::PORT_SEL_FIRST && psel <= dlx_pkg::PORT_SEL_LAST) begin
      op = dlx_pkg::OP_DIR_LOAD;
    end else if (insn[11:dlx_pkg::LIT_XOR_OPC_LSB] == dlx_pkg::LIT_XOR_OPC) begin
      op = dlx_pkg::OP_LIT_XOR;
    end else if (insn[11:dlx_pkg::REG_XOR_OPC_LSB] == dlx_pkg::REG_XOR_OPC) begin
      op = dlx_pkg::OP_REG_XOR;
    end
  end
endmodule

// File: dlx_exec.sv
// execute stage: direction load, literal xor and register xor
`timescale 1ns/1ps
// Function
// - direction-load copies working register to port 5-7
// - direction-load changes no status flag
// - literal-xor xors 8-bit literal with working register
// - literal-xor result to working register only
// - literal-xor updates only zero flag
// - register-xor xors working register with file register
// - dest 0: result to working register
// - dest 1: result to file register
// - register-xor updates only zero flag
module dlx_exec (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // instruction, one per cycle when valid
  input wire logic insn_valid,
  input wire logic [11:0] insn,
  // file register array, combinational read
  output logic [4:0] file_raddr,
  input wire logic [7:0] file_rdata,
  // file register write
  output logic file_we,
  output logic [4:0] file_waddr,
  output logic [7:0] file_wdata,
  // working register and zero flag
  output logic [7:0] wreg,
  output logic zero_flag,
  // port direction latches
  output logic [7:0] first_port_direction,
  output logic [7:0] second_port_direction,
  output logic [7:0] third_port_direction
);
  dlx_pkg::dlx_op_e op;
  logic [7:0] literal;
  logic [4:0] faddr;
  logic dest_file;
  logic [1:0] port_idx;
  logic [7:0] wreg_q;
  logic zero_q;
  logic file_we_q;
  logic [4:0] file_waddr_q;
  logic [7:0] file_wdata_q;
  logic [7:0] dir_q [dlx_pkg::NUM_PORTS];
  logic [7:0] result_d;
  logic lit_x;
  logic reg_x;
  logic dir_x;
  logic fwd_hit;
  logic [7:0] file_opnd;

  // true when this kind of instruction executes this cycle; the update
  // logic and the checks share it so both read the decode the same way
  function automatic logic op_fires(input logic valid, input dlx_pkg::dlx_op_e seen,
    input dlx_pkg::dlx_op_e want);
    return valid && seen == want;
  endfunction

  dlx_decode u_dec (
    .insn(insn),
    .op(op),
    .literal(literal),
    .faddr(faddr),
    .dest_file(dest_file),
    .port_idx(port_idx)
  );

  ////////////////////////////////////////////////////////////////
  assign lit_x = op_fires(insn_valid, op, dlx_pkg::OP_LIT_XOR);
  assign reg_x = op_fires(insn_valid, op, dlx_pkg::OP_REG_XOR);
  assign dir_x = op_fires(insn_valid, op, dlx_pkg::OP_DIR_LOAD);
  assign file_raddr = faddr;

  // the array takes a write one edge after the xor that made it, so a read
  // of that address in the very next cycle would get the stale byte
  assign fwd_hit = file_we_q && file_waddr_q == faddr;
  assign file_opnd = fwd_hit ? file_wdata_q : file_rdata;

  // one xor serves both forms; the literal only swaps the second operand
  always_comb begin
    result_d = wreg_q ^ file_opnd;
    if (lit_x) begin
      result_d = wreg_q ^ literal;
    end
  end

  // working register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wreg_q <= dlx_pkg::WREG_RST;
    end else if (lit_x || (reg_x && !dest_file)) begin
      wreg_q <= result_d;
    end
  end

  // zero flag; a direction load leaves it alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zero_q <= dlx_pkg::ZERO_RST;
    end else if (lit_x || reg_x) begin
      zero_q <= result_d == 8'h00;
    end
  end

  // file write-back, registered so the array sees it one cycle later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      file_we_q <= 1'b0;
      file_waddr_q <= 5'h00;
      file_wdata_q <= 8'h00;
    end else begin
      file_we_q <= reg_x && dest_file;
      file_waddr_q <= faddr;
      file_wdata_q <= result_d;
    end
  end

  // direction latches; select 5..7 lands on latch 0..2, decode refuses the rest
  // reset to all inputs so no pin drives before software has set it up
  for (genvar i = 0; i < dlx_pkg::NUM_PORTS; i++) begin : g_dir
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        dir_q[i] <= dlx_pkg::DIR_RST;
      end else if (dir_x && port_idx == 2'(i)) begin
        dir_q[i] <= wreg_q;
      end
    end
  end

  assign wreg = wreg_q;
  assign zero_flag = zero_q;
  assign file_we = file_we_q;
  assign file_waddr = file_waddr_q;
  assign file_wdata = file_wdata_q;
  assign first_port_direction = dir_q[0];
  assign second_port_direction = dir_q[1];
  assign third_port_direction = dir_q[2];

  ////////////////////////////////////////////////////////////////
  sequence dir_load_s;
    insn_valid && op == dlx_pkg::OP_DIR_LOAD && insn[2:0] == 3'h5;
  endsequence

  sequence dir_second_s;
    dir_x && insn[2:0] == 3'h6;
  endsequence

  sequence dir_third_s;
    dir_x && insn[2:0] == dlx_pkg::PORT_SEL_LAST;
  endsequence

  // this xor reads the byte that the previous one is still writing
  sequence fwd_read_s;
    reg_x && fwd_hit;
  endsequence

  // a file-destined xor straight followed by an xor of the same address
  sequence fwd_chain_s;
    (reg_x && dest_file) ##1 (reg_x && faddr == file_waddr_q);
  endsequence

  // unsupported words and out-of-range port selects
  sequence refused_s;
    op_fires(insn_valid, op, dlx_pkg::OP_NONE);
  endsequence

  // two sampled edges of reset, so the first edge after power-up is skipped
  sequence held_reset_s;
    rst ##1 rst;
  endsequence

  dir_copy_a: assert property (@(posedge clk) disable iff (rst)
    dir_load_s |=> first_port_direction == $past(wreg_q)) else $error("direction load wrong");
  dir_flags_a: assert property (@(posedge clk) disable iff (rst)
    (insn_valid && op == dlx_pkg::OP_DIR_LOAD) |=> $stable(zero_q) && $stable(wreg_q) && !file_we_q)
    else $error("direction load touched state");
  lit_value_a: assert property (@(posedge clk) disable iff (rst)
    lit_x |=> wreg_q == ($past(wreg_q) ^ $past(insn[7:0]))) else $error("literal xor value");
  lit_nofile_a: assert property (@(posedge clk) disable iff (rst)
    lit_x |=> !file_we_q) else $error("literal xor wrote file");
  lit_zero_a: assert property (@(posedge clk) disable iff (rst)
    lit_x |=> zero_q == (wreg_q == 8'h00)) else $error("literal xor zero flag");
  reg_value_a: assert property (@(posedge clk) disable iff (rst)
    (reg_x && !fwd_hit) |=> file_wdata_q == ($past(wreg_q) ^ $past(file_rdata)))
    else $error("register xor value");
  reg_to_w_a: assert property (@(posedge clk) disable iff (rst)
    (reg_x && !dest_file) |=> !file_we_q && wreg_q == file_wdata_q) else $error("dest 0 wrong");
  reg_to_f_a: assert property (@(posedge clk) disable iff (rst)
    (reg_x && dest_file) |=> file_we_q && $stable(wreg_q) && file_waddr_q == $past(faddr))
    else $error("dest 1 wrong");
  reg_zero_a: assert property (@(posedge clk) disable iff (rst)
    reg_x |=> zero_q == (file_wdata_q == 8'h00)) else $error("register xor zero flag");
  idle_zero_a: assert property (@(posedge clk) disable iff (rst)
    !(lit_x || reg_x) |=> $stable(zero_q)) else $error("zero flag moved");
  dir_second_a: assert property (@(posedge clk) disable iff (rst)
    dir_second_s |=> second_port_direction == $past(wreg_q)) else $error("second direction load wrong");
  dir_third_a: assert property (@(posedge clk) disable iff (rst)
    dir_third_s |=> third_port_direction == $past(wreg_q)) else $error("third direction load wrong");
  dir_others_a: assert property (@(posedge clk) disable iff (rst)
    dir_load_s |=> $stable(second_port_direction) && $stable(third_port_direction))
    else $error("direction load hit another latch");
  dir_idle_a: assert property (@(posedge clk) disable iff (rst)
    !dir_x |=> $stable(first_port_direction) && $stable(second_port_direction) && $stable(third_port_direction))
    else $error("direction latch moved");
  lit_dirs_a: assert property (@(posedge clk) disable iff (rst)
    lit_x |=> $stable(first_port_direction) && $stable(second_port_direction) && $stable(third_port_direction))
    else $error("literal xor touched a direction latch");
  reg_dirs_a: assert property (@(posedge clk) disable iff (rst)
    reg_x |=> $stable(first_port_direction) && $stable(second_port_direction) && $stable(third_port_direction))
    else $error("register xor touched a direction latch");
  file_pulse_a: assert property (@(posedge clk) disable iff (rst)
    !(reg_x && dest_file) |=> !file_we_q) else $error("file written without a file-destined xor");
  wreg_hold_a: assert property (@(posedge clk) disable iff (rst)
    !(lit_x || (reg_x && !dest_file)) |=> $stable(wreg_q)) else $error("working register moved");
  fwd_value_a: assert property (@(posedge clk) disable iff (rst)
    fwd_read_s |=> file_wdata_q == ($past(wreg_q) ^ $past(file_wdata_q))) else $error("forwarded xor value");
  fwd_chain_a: assert property (@(posedge clk) disable iff (rst)
    fwd_chain_s |-> fwd_hit) else $error("bypass missed a pending write");
  refused_word_a: assert property (@(posedge clk) disable iff (rst)
    refused_s |=> $stable(wreg_q) && $stable(zero_q) && !file_we_q) else $error("refused word had an effect");
  rst_values_a: assert property (@(posedge clk)
    held_reset_s |-> wreg_q == dlx_pkg::WREG_RST && zero_q == dlx_pkg::ZERO_RST && !file_we_q &&
      first_port_direction == dlx_pkg::DIR_RST) else $error("reset values wrong");
endmodule

// File: dlx_pkg.sv
// package: opcodes, field positions, reset values for the direction-load / xor executor
package dlx_pkg;
  localparam int INSN_W = 12;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 5;
  // direction-load: 0000 0000 0fff
  localparam logic [8:0] DIR_LOAD_OPC = 9'h000;
  localparam int DIR_LOAD_OPC_LSB = 3;
  localparam int PORT_SEL_W = 3;
  localparam logic [2:0] PORT_SEL_FIRST = 3'h5;
  localparam logic [2:0] PORT_SEL_LAST = 3'h7;
  localparam int NUM_PORTS = 3;
  // literal xor: 1111 kkkk kkkk
  localparam logic [3:0] LIT_XOR_OPC = 4'hF;
  localparam int LIT_XOR_OPC_LSB = 8;
  // register xor: 0001 10df ffff
  localparam logic [5:0] REG_XOR_OPC = 6'h06;
  localparam int REG_XOR_OPC_LSB = 6;
  localparam int DEST_BIT = 5;
  localparam logic DEST_WREG = 1'b0;
  // reset values; direction latches come up as all inputs
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic ZERO_RST = 1'b0;
  typedef enum logic [1:0] {OP_NONE, OP_DIR_LOAD, OP_LIT_XOR, OP_REG_XOR} dlx_op_e;
endpackage
